// File: hdl/dram_arb_pkg.sv
// shared constants and types for the dram access and refresh arbiter
package dram_arb_pkg;

	// clock and dram timing
	localparam int CLK_PERIOD_NS    = 4;
	localparam int PRECHARGE_NS     = 60;
	localparam int PRECHARGE_CYCLES = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// refresh ras low time is this base plus the two programming bits
	localparam logic [3:0] REF_LOW_BASE = 4'h2;

	// refresh clock: delay-line rising edges per divider step
	localparam int REFRESH_UNIT_EDGES = 64;

	// programmable access intervals are this base plus the programmed bits
	localparam logic [3:0] ROW_HOLD_BASE   = 4'h1;
	localparam logic [3:0] COL_SETUP_BASE  = 4'h1;

	// staggered refresh grouping codes
	localparam logic [1:0] GROUP_SINGLE = 2'h0;
	localparam logic [1:0] GROUP_PAIRS  = 2'h1;

	// reset values
	localparam logic [9:0] ADDR_RESET     = 10'h000;
	localparam logic [9:0] REF_ROW_RESET  = 10'h000;
	localparam logic [3:0] STROBES_IDLE   = 4'hf;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ROW  = 5'b00010,
		ST_COL  = 5'b00100,
		ST_CAS  = 5'b01000,
		ST_REF  = 5'b10000
	} arb_state_t;

endpackage

// File: hdl/refresh_clock_divider.sv
// refresh clock: synchronises the delay-line clock and divides it into refresh requests
`timescale 1ns/1ps
module refresh_clock_divider
	import dram_arb_pkg::*;
#(
	parameter int UNIT_EDGES = REFRESH_UNIT_EDGES
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// delay-line clock pin and divider setting
	input  wire logic       delay_line_clock,
	input  wire logic [3:0] divider_bits,
	// one-cycle request per refresh clock period
	output logic            tick
);

	logic        dl_s1;
	logic        dl_s2;
	logic        dl_s3;
	logic [15:0] unit_cnt;
	logic [3:0]  step_cnt;
	logic        dl_rise;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dl_s1 <= 1'b0;
			dl_s2 <= 1'b0;
			dl_s3 <= 1'b0;
		end
		else
		begin
			dl_s1 <= delay_line_clock;
			dl_s2 <= dl_s1;
			dl_s3 <= dl_s2;
		end
	end

	assign dl_rise = dl_s2 & ~dl_s3;

	// period is (divider_bits + 1) * UNIT_EDGES delay-line rising edges
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			unit_cnt <= 16'h0000;
			step_cnt <= 4'h0;
			tick     <= 1'b0;
		end
		else
		begin
			tick <= 1'b0;
			if (dl_rise)
			begin
				if (unit_cnt == 16'(UNIT_EDGES - 1))
				begin
					unit_cnt <= 16'h0000;
					if (step_cnt >= divider_bits)
					begin
						step_cnt <= 4'h0;
						tick     <= 1'b1;
					end
					else
						step_cnt <= step_cnt + 4'h1;
				end
				else
					unit_cnt <= unit_cnt + 16'h0001;
			end
		end
	end

endmodule

// File: hdl/address_capture.sv
// address latches: transparent while ale is high or fall_through is set, otherwise closed at the falling edge of ale
`timescale 1ns/1ps
module address_capture
	import dram_arb_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic       ale,
	input  wire logic       fall_through,
	// address inputs
	input  wire logic [1:0] bank_in,
	input  wire logic [9:0] row_in,
	input  wire logic [9:0] col_in,
	// address as seen by the access logic
	output logic      [1:0] bank,
	output logic      [9:0] row,
	output logic      [9:0] col
);

	logic [1:0] bank_held;
	logic [9:0] row_held;
	logic [9:0] col_held;
	logic       open;

	assign open = fall_through | ale;

	// the last value loaded while ale is high is what the falling edge keeps
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bank_held <= 2'h0;
			row_held  <= ADDR_RESET;
			col_held  <= ADDR_RESET;
		end
		else if (ale)
		begin
			bank_held <= bank_in;
			row_held  <= row_in;
			col_held  <= col_in;
		end
	end

	assign bank = open ? bank_in : bank_held;
	assign row  = open ? row_in : row_held;
	assign col  = open ? col_in : col_held;

endmodule

// File: hdl/dram_access_refresh_arbiter.sv
// dram controller: access sequencing, refresh generation and arbitration
`timescale 1ns/1ps
module dram_access_refresh_arbiter
	import dram_arb_pkg::*;
#(
	parameter int REFRESH_UNIT = REFRESH_UNIT_EDGES
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// host access control
	input  wire logic       ale,
	input  wire logic       cs_n,
	input  wire logic       timing_state_strobe_n,
	input  wire logic       wait_extend_in_n,
	input  wire logic       write_enable_in_n,
	input  wire logic [3:0] cas_enable_in_n,
	output logic            wait_n,
	// host address
	input  wire logic [1:0] bank_in,
	input  wire logic [9:0] row_in,
	input  wire logic [9:0] col_in,
	// dram side
	output logic      [9:0] dram_address_out,
	output logic      [3:0] ras_n,
	output logic      [3:0] cas_n,
	output logic            we_n,
	// refresh pins
	input  wire logic       delay_line_clock,
	input  wire logic       refresh_inhibit,
	input  wire logic       refresh_counter_clear_n,
	// programming bits
	input  wire logic       address_latch_option_bit,
	input  wire logic       access_mode_bit,
	input  wire logic [1:0] refresh_ras_low_time_bits,
	input  wire logic [3:0] refresh_clock_divider_bits,
	input  wire logic       refresh_type_bit,
	input  wire logic [1:0] ras_group_bits,
	input  wire logic [1:0] wait_state_bits,
	input  wire logic [1:0] row_hold_bits,
	input  wire logic [1:0] col_setup_bits,
	// status
	output logic            internal_refresh_request,
	output logic            refresh_in_progress,
	output logic            access_in_progress
);

	arb_state_t state;
	arb_state_t next_state;

	logic       acc_req;
	logic       req_now;
	logic       prech_ok;
	logic [4:0] prech_cnt;
	logic [3:0] tcnt;
	logic       tso_seen;
	logic       tso_end;
	logic       start_acc;
	logic       start_ref;
	logic       ref_tick;
	logic [3:0] ref_cnt;
	logic [3:0] ref_low;
	logic [3:0] ref_last;
	logic [3:0] ras_delay [4];
	logic [3:0] next_ref_ras;
	logic [9:0] ref_row;
	logic       wait_hold;
	logic [1:0] wait_cnt;
	logic       zero_wait_now;
	logic [1:0] bank;
	logic [9:0] row;
	logic [9:0] col;
	logic       inh_s1;
	logic       inh_s2;
	logic       clr_s1;
	logic       clr_s2;
	logic       auto_refresh_on;
	logic       cas_on;

	// refresh pins are asynchronous to clk
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			inh_s1 <= 1'b1;
			inh_s2 <= 1'b1;
			clr_s1 <= 1'b1;
			clr_s2 <= 1'b1;
		end
		else
		begin
			inh_s1 <= refresh_inhibit;
			inh_s2 <= inh_s1;
			clr_s1 <= refresh_counter_clear_n;
			clr_s2 <= clr_s1;
		end
	end

	assign auto_refresh_on = ~inh_s2;

	address_capture u_addr (
		.clk          (clk),
		.rst          (rst),
		.ale          (ale),
		.fall_through (address_latch_option_bit),
		.bank_in      (bank_in),
		.row_in       (row_in),
		.col_in       (col_in),
		.bank         (bank),
		.row          (row),
		.col          (col)
	);

	refresh_clock_divider #(
		.UNIT_EDGES (REFRESH_UNIT)
	) u_rclk (
		.clk              (clk),
		.rst              (rst),
		.delay_line_clock (delay_line_clock),
		.divider_bits     (refresh_clock_divider_bits),
		.tick             (ref_tick)
	);

	// a request counts only with chip select; the latch covers a one-cycle ale pulse
	assign req_now  = acc_req | (ale & ~cs_n);
	assign prech_ok = (prech_cnt == 5'h00);

	// pending refresh goes ahead of a new access; a running access is never cut
	assign start_ref = (state == ST_IDLE) & internal_refresh_request & prech_ok;
	assign start_acc = (state == ST_IDLE) & req_now & prech_ok & ~start_ref;

	// access ends once the strobe has been seen and is negated again
	assign tso_end = tso_seen & timing_state_strobe_n;

	assign ref_low = REF_LOW_BASE + {2'h0, refresh_ras_low_time_bits};
	assign ref_last = ref_low + (refresh_type_bit ? ras_delay[3] : 4'h0) - 4'h1;

	// staggered refresh offsets per ras output
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_ras
			always_comb
			begin
				if (!refresh_type_bit)
					ras_delay[gi] = 4'h0;
				else if (ras_group_bits == GROUP_SINGLE)
					ras_delay[gi] = 4'(gi);
				else if (ras_group_bits == GROUP_PAIRS)
					ras_delay[gi] = 4'(gi / 2);
				else
					ras_delay[gi] = 4'h0;
			end

			// level of this refresh ras in the next cycle, for the ref_cnt of that cycle
			always_comb
			begin
				if (state == ST_IDLE)
					next_ref_ras[gi] = start_ref & (ras_delay[gi] == 4'h0);
				else if (state == ST_REF && ref_cnt != ref_last)
					next_ref_ras[gi] = (ref_cnt + 4'h1 >= ras_delay[gi])
						& (ref_cnt + 4'h1 < ras_delay[gi] + ref_low);
				else
					next_ref_ras[gi] = 1'b0;
			end
		end
	endgenerate

	// arbitration state
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_IDLE:
			begin
				if (start_ref)
					next_state = ST_REF;
				else if (start_acc)
					next_state = ST_ROW;
			end
			ST_ROW:
			begin
				if (tso_end)
					next_state = ST_IDLE;
				else if (tcnt == ROW_HOLD_BASE + {2'h0, row_hold_bits} - 4'h1)
					next_state = ST_COL;
			end
			ST_COL:
			begin
				if (tso_end)
					next_state = ST_IDLE;
				else if (tcnt == COL_SETUP_BASE + {2'h0, col_setup_bits} - 4'h1)
					next_state = ST_CAS;
			end
			ST_CAS:
			begin
				if (tso_end)
					next_state = ST_IDLE;
			end
			ST_REF:
			begin
				if (ref_cnt == ref_last)
					next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// interval counter for row hold and column setup
	always_ff @(posedge clk)
	begin
		if (rst)
			tcnt <= 4'h0;
		else if (next_state != state)
			tcnt <= 4'h0;
		else
			tcnt <= tcnt + 4'h1;
	end

	// access request latch and strobe tracking
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc_req  <= 1'b0;
			tso_seen <= 1'b0;
		end
		else
		begin
			if (start_acc)
				acc_req <= 1'b0;
			else if (ale & ~cs_n)
				acc_req <= 1'b1;
			if (start_acc)
				tso_seen <= 1'b0;
			else if (access_in_progress & ~timing_state_strobe_n)
				tso_seen <= 1'b1;
		end
	end

	// precharge after every ras negation
	always_ff @(posedge clk)
	begin
		if (rst)
			prech_cnt <= 5'h00;
		else if (state != ST_IDLE && next_state == ST_IDLE)
			prech_cnt <= 5'(PRECHARGE_CYCLES);
		else if (!prech_ok)
			prech_cnt <= prech_cnt - 5'h01;
	end

	// refresh request flag: set wins over the clear by refresh start
	always_ff @(posedge clk)
	begin
		if (rst)
			internal_refresh_request <= 1'b0;
		else if (!auto_refresh_on)
			internal_refresh_request <= 1'b0;
		else if (ref_tick)
			internal_refresh_request <= 1'b1;
		else if (start_ref)
			internal_refresh_request <= 1'b0;
	end

	// refresh cycle counter and row address counter
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ref_cnt <= 4'h0;
			ref_row <= REF_ROW_RESET;
		end
		else
		begin
			if (state == ST_REF)
				ref_cnt <= ref_cnt + 4'h1;
			else
				ref_cnt <= 4'h0;
			if (!clr_s2 && !inh_s2)
				ref_row <= REF_ROW_RESET;
			else if (state == ST_REF && next_state == ST_IDLE)
				ref_row <= ref_row + 10'h001;
		end
	end

	// status flags
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			refresh_in_progress <= 1'b0;
			access_in_progress  <= 1'b0;
		end
		else
		begin
			refresh_in_progress <= (next_state == ST_REF);
			access_in_progress  <= (next_state == ST_ROW) | (next_state == ST_COL)
				| (next_state == ST_CAS);
		end
	end

	// ras, cas, write enable and multiplexed address
	assign cas_on = (next_state == ST_CAS);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ras_n            <= STROBES_IDLE;
			cas_n            <= STROBES_IDLE;
			we_n             <= 1'b1;
			dram_address_out <= ADDR_RESET;
		end
		else
		begin
			we_n <= write_enable_in_n;
			if (start_acc)
			begin
				ras_n            <= ~(4'h1 << bank);
				dram_address_out <= row;
			end
			else if (state == ST_REF || start_ref)
			begin
				ras_n            <= ~next_ref_ras;
				dram_address_out <= ref_row;
			end
			else if (next_state == ST_IDLE)
				ras_n <= STROBES_IDLE;
			if (next_state == ST_COL)
				dram_address_out <= col;
			if (cas_on)
				cas_n <= cas_enable_in_n;
			else
				cas_n <= STROBES_IDLE;
		end
	end

	// wait: zero-wait mode on a non-delayed access asserts it only when wait_extend_in_n is low at the start
	assign zero_wait_now = (wait_state_bits == 2'h0) & start_acc & ~acc_req;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wait_hold <= 1'b0;
			wait_cnt  <= 2'h0;
		end
		else if (start_acc)
		begin
			wait_cnt  <= wait_state_bits;
			wait_hold <= (wait_state_bits != 2'h0) | ~wait_extend_in_n;
		end
		else if (access_in_progress)
		begin
			if (wait_extend_in_n)
			begin
				if (wait_cnt <= 2'h1)
					wait_hold <= 1'b0;
				if (wait_cnt != 2'h0)
					wait_cnt <= wait_cnt - 2'h1;
			end
		end
		else if (req_now & ~timing_state_strobe_n)
			wait_hold <= wait_hold;
		else if (req_now)
			wait_hold <= 1'b1;
		else
			wait_hold <= 1'b0;
	end

	// follows chip select combinationally until the sampling edge
	assign wait_n = ~(wait_hold
		| (ale & ~cs_n & ~access_in_progress & ~zero_wait_now));

endmodule

// File: bench/dram_arb_sva.sv
// assertion checker for the dram access and refresh arbiter
`timescale 1ns/1ps
module dram_arb_sva
	import dram_arb_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// host side
	input wire logic       ale,
	input wire logic       cs_n,
	input wire logic       timing_state_strobe_n,
	input wire logic       wait_extend_in_n,
	input wire logic       wait_n,
	// dram side
	input wire logic [3:0] ras_n,
	input wire logic [3:0] cas_n,
	// programming and status
	input wire logic       refresh_inhibit,
	input wire logic [1:0] refresh_ras_low_time_bits,
	input wire logic       refresh_type_bit,
	input wire logic [1:0] ras_group_bits,
	input wire logic [1:0] wait_state_bits,
	input wire logic       refresh_in_progress,
	input wire logic       access_in_progress
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// cycles that all four row strobes have been low
	logic [3:0] low_cnt;
	always_ff @(posedge clk)
	begin
		if (rst || ras_n != 4'h0)
			low_cnt <= 4'h0;
		else
			low_cnt <= low_cnt + 4'h1;
	end

	// staggered patterns for a two-cycle low time
	sequence single_seq;
		ras_n == 4'hc ##1 ras_n == 4'h9 ##1 ras_n == 4'h3 ##1 ras_n == 4'h7 ##1 ras_n == 4'hf;
	endsequence
	sequence pair_seq;
		ras_n == 4'h0 ##1 ras_n == 4'h3 ##1 ras_n == 4'hf;
	endsequence

	ref_low_time_a: assert property (
		ras_n == 4'hf && $past(ras_n) == 4'h0 |-> low_cnt == REF_LOW_BASE + refresh_ras_low_time_bits)
		else $error("refresh strobe low time wrong");
	stagger_single_a: assert property (
		!access_in_progress && refresh_type_bit && ras_group_bits == GROUP_SINGLE
		&& refresh_ras_low_time_bits == 2'h0 && ras_n == 4'he && $past(ras_n) == 4'hf |=> single_seq)
		else $error("single staggered refresh order wrong");
	stagger_pair_a: assert property (
		!access_in_progress && refresh_type_bit && ras_group_bits == GROUP_PAIRS
		&& refresh_ras_low_time_bits == 2'h0 && ras_n == 4'hc && $past(ras_n) == 4'hf |=> pair_seq)
		else $error("paired staggered refresh order wrong");
	access_end_a: assert property (
		access_in_progress && $rose(timing_state_strobe_n) |=> ras_n == 4'hf && cas_n == 4'hf)
		else $error("strobes not released at access end");
	wait_assert_a: assert property (
		ale && !cs_n && wait_state_bits != 2'h0 |-> !wait_n)
		else $error("wait not asserted on request");
	wait_release_a: assert property (
		$rose(access_in_progress) && wait_extend_in_n |-> ##[0:4] wait_n)
		else $error("wait not released after access start");
	wait_extend_a: assert property (
		access_in_progress && !wait_extend_in_n && !wait_n |=> !wait_n)
		else $error("wait released while extended");
	refresh_excl_a: assert property (
		access_in_progress |-> !refresh_in_progress)
		else $error("refresh during access");
	access_hold_a: assert property (
		access_in_progress && !timing_state_strobe_n |=> access_in_progress)
		else $error("access cut short");
	inhibit_stop_a: assert property (
		refresh_inhibit [*6] |-> !$rose(refresh_in_progress))
		else $error("refresh started while inhibited");
	ras_with_access_a: assert property (
		$rose(access_in_progress) |-> ras_n != 4'hf)
		else $error("access without row strobe");
endmodule

// File: bench/host_bus_model.sv
// host bus model: runs access cycles on the falling clock edge
`timescale 1ns/1ps
module host_bus_model
	import dram_arb_pkg::*;
(
	// clock
	input  wire logic       clk,
	// what the host sees
	input  wire logic       wait_n,
	input  wire logic [3:0] ras_n,
	input  wire logic [3:0] cas_n,
	// host bus
	output logic            ale,
	output logic            cs_n,
	output logic            timing_state_strobe_n,
	output logic            write_enable_in_n,
	output logic      [1:0] bank_in,
	output logic      [9:0] row_in,
	output logic      [9:0] col_in
);
	initial
	begin
		ale = 1'b0;
		cs_n = 1'b1;
		timing_state_strobe_n = 1'b1;
		write_enable_in_n = 1'b1;
		{bank_in, row_in, col_in} = 22'h00_0000;
	end

	// use_cs low pulses ale with chip select negated
	task automatic access(input logic [1:0] b, input logic [9:0] r, input logic [9:0] c,
		input logic wr, input logic use_cs);
		int n;
		@(negedge clk);
		ale = 1'b1;
		cs_n = ~use_cs;
		{bank_in, row_in, col_in} = {b, r, c};
		@(negedge clk);
		ale = 1'b0;
		// lines no longer valid once ale falls
		{bank_in, row_in, col_in} = ~{b, r, c};
		n = 0;
		while (use_cs && (wait_n !== 1'b1 || ras_n[b]) && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		if (use_cs)
		begin
			@(negedge clk);
			timing_state_strobe_n = 1'b0;
			cs_n = 1'b1;
			n = 0;
			while (cas_n == STROBES_IDLE && n < 20)
			begin
				@(negedge clk);
				n++;
			end
			write_enable_in_n = ~wr;
			repeat (2) @(negedge clk);
			timing_state_strobe_n = 1'b1;
			write_enable_in_n = 1'b1;
		end
	endtask
endmodule

// File: bench/dram_access_refresh_arbiter_test.sv
// self-checking testbench for the dram access and refresh arbiter
`timescale 1ns/1ps
module dram_access_refresh_arbiter_test
	import dram_arb_pkg::*;
;
	typedef struct packed {logic [1:0] b; logic [9:0] r; logic [9:0] c;} note_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        delay_line_clock = 1'b0;
	logic        wait_extend_in_n = 1'b1;
	logic [3:0]  cas_enable_in_n = 4'h0;
	logic        refresh_inhibit = 1'b1;
	logic        refresh_counter_clear_n = 1'b1;
	logic [1:0]  refresh_ras_low_time_bits = 2'h0;
	logic [3:0]  refresh_clock_divider_bits = 4'h3;
	logic        refresh_type_bit = 1'b0;
	logic [1:0]  ras_group_bits = 2'h0;
	logic [1:0]  wait_state_bits = 2'h0;
	logic [1:0]  row_hold_bits = 2'h0;
	logic [1:0]  col_setup_bits = 2'h0;
	logic        ale, cs_n, timing_state_strobe_n, write_enable_in_n, wait_n, we_n;
	logic [1:0]  bank_in;
	logic [9:0]  row_in, col_in, dram_address_out;
	logic [3:0]  ras_n, cas_n;
	logic        internal_refresh_request, refresh_in_progress, access_in_progress;
	logic [31:0] seed = 32'h2ee2_76ac;
	logic [9:0]  ref_row = REF_ROW_RESET;
	logic [3:0]  prev_ras = 4'hf;
	logic [3:0]  prev_cas = 4'hf;
	logic        prev_win = 1'b1;
	note_t       notes[$];
	note_t       cur;
	int          bad_count = 0;
	int          compares = 0;
	int          ref_seen = 0;
	int          s;

	dram_access_refresh_arbiter #(.REFRESH_UNIT(2)) u_dram_access_refresh_arbiter (
		.clk(clk), .rst(rst), .ale(ale), .cs_n(cs_n),
		.timing_state_strobe_n(timing_state_strobe_n), .wait_extend_in_n(wait_extend_in_n),
		.write_enable_in_n(write_enable_in_n), .cas_enable_in_n(cas_enable_in_n),
		.wait_n(wait_n), .bank_in(bank_in), .row_in(row_in), .col_in(col_in),
		.dram_address_out(dram_address_out), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.delay_line_clock(delay_line_clock), .refresh_inhibit(refresh_inhibit),
		.refresh_counter_clear_n(refresh_counter_clear_n),
		.address_latch_option_bit(1'b0), .access_mode_bit(1'b0),
		.refresh_ras_low_time_bits(refresh_ras_low_time_bits),
		.refresh_clock_divider_bits(refresh_clock_divider_bits),
		.refresh_type_bit(refresh_type_bit), .ras_group_bits(ras_group_bits),
		.wait_state_bits(wait_state_bits), .row_hold_bits(row_hold_bits),
		.col_setup_bits(col_setup_bits), .internal_refresh_request(internal_refresh_request),
		.refresh_in_progress(refresh_in_progress), .access_in_progress(access_in_progress));

	host_bus_model u_host_bus_model (
		.clk(clk), .wait_n(wait_n), .ras_n(ras_n), .cas_n(cas_n), .ale(ale), .cs_n(cs_n),
		.timing_state_strobe_n(timing_state_strobe_n), .write_enable_in_n(write_enable_in_n),
		.bank_in(bank_in), .row_in(row_in), .col_in(col_in));

	always #2 clk = ~clk;
	always #7 delay_line_clock = ~delay_line_clock;

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic do_access(input logic wr);
		note_t n;
		seed = lfsr(seed);
		n = seed[21:0];
		cas_enable_in_n = {seed[25:23], 1'b0};
		notes.push_back(n);
		u_host_bus_model.access(n.b, n.r, n.c, wr, 1'b1);
	endtask

	task automatic program_refresh(input logic t, input logic [1:0] g, input logic [1:0] lb,
		input logic [3:0] dv);
		refresh_inhibit = 1'b1;
		repeat (30) @(negedge clk);
		check({9'h0, internal_refresh_request}, 10'h0);
		{refresh_type_bit, ras_group_bits, refresh_ras_low_time_bits} = {t, g, lb};
		refresh_clock_divider_bits = dv;
		refresh_inhibit = 1'b0;
	endtask

	task automatic wait_refresh();
		int n;
		n = ref_seen;
		for (int i = 0; i < 400 && ref_seen == n; i++)
			@(negedge clk);
		check({9'h0, ref_seen != n}, 10'h1);
	endtask

	// compares row, column and refresh row as the first row or column strobe falls from all high
	always @(negedge clk)
	begin
		if (!rst && prev_ras == 4'hf && ras_n != 4'hf)
		begin
			if (access_in_progress === 1'b1)
			begin
				if (notes.size() == 0)
					check(10'h3ff, 10'h0);
				else
					cur = notes.pop_front();
				check(dram_address_out, cur.r);
				check({6'h0, ras_n}, {6'h0, ~(4'h1 << cur.b)});
			end
			else
			begin
				check(dram_address_out, ref_row);
				ref_row = ref_row + 10'h1;
				ref_seen++;
			end
		end
		if (!rst && prev_cas == 4'hf && cas_n != 4'hf)
		begin
			check(dram_address_out, cur.c);
			check({6'h0, cas_n}, {6'h0, cas_enable_in_n});
		end
		if (!rst)
			check({9'h0, we_n}, {9'h0, prev_win});
		prev_ras = ras_n;
		prev_cas = cas_n;
	end

	// write input as the design sampled it at the last rising edge
	always @(posedge clk)
		prev_win <= write_enable_in_n;

	initial
	begin
		#100000;
		bad_count++;
		finish_test();
	end

	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check({cas_n, ras_n, we_n, wait_n}, {STROBES_IDLE, STROBES_IDLE, 2'h3});
		check(dram_address_out, ADDR_RESET);
		// back-to-back accesses over the wait and interval settings
		for (int i = 0; i < 8; i++)
		begin
			{wait_state_bits, row_hold_bits, col_setup_bits} = {i[1:0], i[2:1], ~i[1:0]};
			do_access(i[0]);
		end
		// ale without chip select starts nothing
		u_host_bus_model.access(2'h1, 10'h155, 10'h2aa, 1'b0, 1'b0);
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk);
			check({6'h0, ras_n}, {6'h0, STROBES_IDLE});
		end
		wait_state_bits = 2'h1;
		wait_extend_in_n = 1'b0;
		fork
			begin
				repeat (8) @(negedge clk);
				check({9'h0, wait_n}, 10'h0);
				wait_extend_in_n = 1'b1;
			end
		join_none
		do_access(1'b0);
		// clearing the refresh row counter mid-run
		program_refresh(1'b0, 2'h0, 2'h0, 4'hf);
		wait_refresh();
		repeat (20) @(negedge clk);
		refresh_counter_clear_n = 1'b0;
		ref_row = REF_ROW_RESET;
		repeat (4) @(negedge clk);
		refresh_counter_clear_n = 1'b1;
		wait_refresh();
		for (int i = 0; i < 7; i++)
		begin
			program_refresh(i > 3, i[1:0], (i > 3) ? 2'h0 : i[1:0], 4'h3);
			wait_refresh();
			wait_refresh();
		end
		// accesses competing with refresh
		for (int i = 0; i < 6; i++)
			do_access(i[0]);
		refresh_inhibit = 1'b1;
		repeat (20) @(negedge clk);
		s = ref_seen;
		repeat (100) @(negedge clk);
		check(10'(ref_seen - s), 10'h0);
		check(10'(notes.size()), 10'h0);
		finish_test();
	end
endmodule

bind dram_access_refresh_arbiter dram_arb_sva u_dram_arb_sva (
	.clk(clk), .rst(rst), .ale(ale), .cs_n(cs_n), .wait_n(wait_n),
	.timing_state_strobe_n(timing_state_strobe_n), .wait_extend_in_n(wait_extend_in_n),
	.ras_n(ras_n), .cas_n(cas_n), .refresh_inhibit(refresh_inhibit),
	.refresh_ras_low_time_bits(refresh_ras_low_time_bits), .refresh_type_bit(refresh_type_bit),
	.ras_group_bits(ras_group_bits), .wait_state_bits(wait_state_bits),
	.refresh_in_progress(refresh_in_progress), .access_in_progress(access_in_progress));
